//--- chsel_target.sv
// serial-bus target for four-channel bus multiplexer control
`timescale 1ns/1ps
`default_nettype none
module chsel_target
    import chsel_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = CHSEL_DEV_ADDR_DEFAULT
)(
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // upstream bus
    input  wire logic                    scl_in,
    input  wire logic                    sda_in,
    output logic                         sda_out,
    output logic                         sda_oe,
    // downstream channel enables, one-hot or none
    output logic [CHSEL_NUM_CH-1:0]      ch_enable
);
    chsel_sync_if ev ();

    chsel_state_t state;
    logic [7:0]   shift;
    logic [3:0]   bit_cnt;
    logic [2:0]   ctrl;
    logic [2:0]   pending;
    logic         pend_valid;
    logic [7:0]   tx_byte;
    logic [7:0]   rd_byte;

    // readback image; top five bits always read as zero
    assign rd_byte = {5'h00, ctrl};

    chsel_sync u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .ev      (ev)
    );

    // state machine; bits sampled on scl rise, driven after scl fall
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state   <= CHSEL_IDLE;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
        end else if (ev.start_det) begin
            state   <= CHSEL_ADDR;
            bit_cnt <= 4'h0;
        end else if (ev.stop_det) begin
            state   <= CHSEL_IDLE;
        end else begin
            case (state)
                CHSEL_IDLE, CHSEL_IGNORE: begin
                    bit_cnt <= 4'h0;
                end
                CHSEL_ADDR: begin
                    if (ev.scl_rise) begin
                        shift   <= {shift[6:0], ev.sda_level};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (ev.scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (shift[7:1] == DEV_ADDR) begin
                            state <= CHSEL_ACK_A;
                        end else begin
                            state <= CHSEL_IGNORE;
                        end
                    end
                end
                CHSEL_ACK_A: begin
                    if (ev.scl_fall) begin
                        state <= (shift[0] == CHSEL_DIR_READ) ?
                                 CHSEL_RDATA : CHSEL_WDATA;
                    end
                end
                CHSEL_WDATA: begin
                    if (ev.scl_rise) begin
                        shift   <= {shift[6:0], ev.sda_level};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (ev.scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        state   <= CHSEL_ACK_W;
                    end
                end
                CHSEL_ACK_W: begin
                    if (ev.scl_fall) begin
                        state <= CHSEL_WDATA;
                    end
                end
                CHSEL_RDATA: begin
                    if (ev.scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (ev.scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        state   <= CHSEL_RACK;
                    end
                end
                CHSEL_RACK: begin
                    // master ack continues, nack ends the read
                    if (ev.scl_rise) begin
                        state <= ev.sda_level ? CHSEL_IGNORE
                                              : CHSEL_RDATA;
                    end
                end
                default: begin
                    state <= CHSEL_IDLE;
                end
            endcase
        end
    end

    // each completed write data byte overwrites the pending choice
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pending    <= CHSEL_NONE;
            pend_valid <= 1'b0;
        end else if (ev.start_det || ev.stop_det) begin
            pend_valid <= 1'b0;
        end else if (state == CHSEL_WDATA && ev.scl_fall
                     && bit_cnt == 4'h8) begin
            pending    <= shift[CHSEL_CH_MSB:CHSEL_CH_LSB];
            pend_valid <= 1'b1;
        end
    end

    // a repeated start drops an unfinished write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl <= CHSEL_CTRL_RESET[CHSEL_CH_MSB:CHSEL_CH_LSB];
        end else if (ev.stop_det && pend_valid) begin
            ctrl <= pending;
        end
    end

    // channel code 1..4 picks one channel, anything else none
    genvar gi;
    generate
        for (gi = 0; gi < CHSEL_NUM_CH; gi++) begin : g_ch
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    ch_enable[gi] <= 1'b0;
                end else begin
                    ch_enable[gi] <= (ctrl == 3'(gi + 1));
                end
            end
        end
    endgenerate

    // readback byte, reloaded for every read byte; the master's ack
    // is taken on the rise, so the reload falls in rdata at count zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_byte <= 8'h00;
        end else if (ev.scl_fall && (state == CHSEL_ACK_A
                     || (state == CHSEL_RDATA && bit_cnt == 4'h0))) begin
            tx_byte <= rd_byte;
        end else if (state == CHSEL_RDATA && ev.scl_fall) begin
            tx_byte <= {tx_byte[6:0], 1'b0};
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sda_oe <= 1'b0;
        end else if (ev.start_det || ev.stop_det) begin
            sda_oe <= 1'b0;
        end else if (ev.scl_fall) begin
            case (state)
                CHSEL_ADDR: begin
                    sda_oe <= (bit_cnt == 4'h8) &&
                              (shift[7:1] == DEV_ADDR);
                end
                CHSEL_WDATA: begin
                    sda_oe <= (bit_cnt == 4'h8);
                end
                CHSEL_ACK_A: begin
                    // first read bit comes from the fresh image
                    sda_oe <= (shift[0] == CHSEL_DIR_READ)
                              && !rd_byte[7];
                end
                CHSEL_RACK: begin
                    // not reached: the ack rise already left this state
                    sda_oe <= 1'b0;
                end
                CHSEL_RDATA: begin
                    if (bit_cnt == 4'h8) begin
                        sda_oe <= 1'b0; // leave the ack slot to the master
                    end else if (bit_cnt == 4'h0) begin
                        sda_oe <= ~rd_byte[7];
                    end else begin
                        sda_oe <= ~tx_byte[6];
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end
endmodule : chsel_target
`default_nettype wire

//--- chsel_pkg.sv
// shared constants for the channel select serial-bus target
package chsel_pkg;
    localparam logic [6:0] CHSEL_DEV_ADDR_DEFAULT = 7'h70; // arbitrary value
    localparam int         CHSEL_CH_LSB           = 0;
    localparam int         CHSEL_CH_MSB           = 2;
    localparam logic [7:0] CHSEL_CTRL_RESET       = 8'h00;
    localparam logic [2:0] CHSEL_NONE             = 3'h0;
    localparam int         CHSEL_NUM_CH           = 4;
    localparam logic       CHSEL_DIR_WRITE        = 1'b0;
    localparam logic       CHSEL_DIR_READ         = 1'b1;

    typedef enum logic [2:0] {
        CHSEL_IDLE   = 3'b000,
        CHSEL_ADDR   = 3'b001,
        CHSEL_ACK_A  = 3'b010,
        CHSEL_WDATA  = 3'b011,
        CHSEL_ACK_W  = 3'b100,
        CHSEL_RDATA  = 3'b101,
        CHSEL_RACK   = 3'b110,
        CHSEL_IGNORE = 3'b111
    } chsel_state_t;
endpackage : chsel_pkg

//--- chsel_sync_if.sv
// carries synchronised bus levels and detected bus events
`timescale 1ns/1ps
`default_nettype none
interface chsel_sync_if;
    logic scl_rise;
    logic scl_fall;
    logic sda_level;
    logic start_det;
    logic stop_det;
    modport src (output scl_rise, scl_fall, sda_level, start_det, stop_det);
    modport dst (input  scl_rise, scl_fall, sda_level, start_det, stop_det);
endinterface : chsel_sync_if
`default_nettype wire

//--- chsel_sync.sv
// two-flop synchronisers and bus event detection
`timescale 1ns/1ps
`default_nettype none
module chsel_sync
    import chsel_pkg::*;
(
    // clock and reset
    input  wire logic  sys_clk,
    input  wire logic  rst,
    // bus pins
    input  wire logic  scl_in,
    input  wire logic  sda_in,
    // events
    chsel_sync_if.src  ev
);
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic       scl_q;
    logic       sda_q;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
        end else begin
            scl_meta <= {scl_meta[0], scl_in};
            sda_meta <= {sda_meta[0], sda_in};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_meta[1];
            sda_q <= sda_meta[1];
        end
    end

    assign ev.scl_rise  = scl_meta[1] & ~scl_q;
    assign ev.scl_fall  = ~scl_meta[1] & scl_q;
    assign ev.sda_level = sda_meta[1];
    // sda moving while scl stays high marks start or stop
    assign ev.start_det = scl_meta[1] & scl_q & sda_q & ~sda_meta[1];
    assign ev.stop_det  = scl_meta[1] & scl_q & ~sda_q & sda_meta[1];
endmodule : chsel_sync
`default_nettype wire

//--- chsel_chk.sv
// concurrent checks on the channel select target ports
`timescale 1ns/1ps
`default_nettype none
module chsel_chk (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // bus pins and channel enables
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [3:0] ch_enable
);
    logic [3:0] stop_age;
    // raw pin stop; the design lags it by its synchroniser
    always_ff @(posedge sys_clk) begin
        if (rst) stop_age <= 4'hf;
        else if (scl_in && $past(scl_in) && $rose(sda_in)) stop_age <= 4'h0;
        else if (stop_age != 4'hf) stop_age <= stop_age + 4'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_rst; $fell(rst) |-> ch_enable == 4'h0 && !sda_oe; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_hot; $onehot0(ch_enable); endproperty
    a_hot: assert property (p_hot) else $error("two channels");
    property p_stop; !$stable(ch_enable) |-> stop_age <= 4'h9; endproperty
    a_stop: assert property (p_stop) else $error("early switch");
    property p_once;
        !$stable(ch_enable) |=> $stable(ch_enable) [*8];
    endproperty
    a_once: assert property (p_once) else $error("second switch");
    property p_low; !$stable(sda_oe) |-> !scl_in; endproperty
    a_low: assert property (p_low) else $error("data moved");
    property p_held; $rose(sda_oe) |=> sda_oe [*4]; endproperty
    a_held: assert property (p_held) else $error("short drive");
    property p_quiet; stop_age < 4'h4 |-> !sda_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("drive at stop");
    property p_od; sda_oe |-> !sda_out; endproperty
    a_od: assert property (p_od) else $error("not open drain");
endmodule : chsel_chk
bind chsel_target chsel_chk u_chk (.sys_clk, .rst, .scl_in, .sda_in,
    .sda_out, .sda_oe, .ch_enable);
`default_nettype wire

//--- chsel_master.sv
// upstream bus master model; clock line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module chsel_master (
    // clock
    input  wire logic sys_clk,
    // bus lines
    input  wire logic sda_bus,
    output var logic  scl,
    output var logic  sda
);
    initial {scl, sda} = 2'b11;
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt
    // start or stop; data first drops with the clock low (stop) or high (start), a stop then raises it with the clock high
    task automatic cond(input logic stp);
        sda <= 1'b0;
        wt(5);
        scl <= stp;
        wt(5);
        sda <= stp;
        wt(5);
    endtask : cond
    task automatic bit_x(input logic b, output logic r);
        sda <= b;
        wt(4);
        scl <= 1'b1;
        wt(3);
        r = sda_bus;
        scl <= 1'b0;
        wt(1);
    endtask : bit_x
    task automatic xfer(input logic [7:0] d, input logic a_out,
                        output logic [7:0] r, output logic a_in);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
        bit_x(a_out, a_in);
    endtask : xfer
endmodule : chsel_master
`default_nettype wire

//--- chsel_target_tb.sv
// self-checking bench for the channel select target
`timescale 1ns/1ps
`default_nettype none
module chsel_target_tb;
    import chsel_pkg::*;
    logic       sys_clk = 1'b0, rst = 1'b1, scl_in, sda_m, sda_out, sda_oe, ack;
    logic [3:0] ch_enable;
    logic [7:0] obs, rd, d, exp_q[$];
    logic [2:0] cur = 3'h0;
    int num_errors = 0, cmp_count = 0, seed = 35330, obs_n = 0, seen_n = 0, n;
    wire        sda_in = sda_m & ~sda_oe; // pull-up on the data line
    initial forever #10 sys_clk = ~sys_clk;
    chsel_master u_mst (.sys_clk, .sda_bus(sda_in), .scl(scl_in), .sda(sda_m));
    chsel_target u_dut (.sys_clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe,
        .ch_enable);
    task automatic check(input logic [7:0] v, input logic [7:0] e);
        cmp_count++;
        if (v !== e) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, v, e);
        end
    endtask : check
    // note first, so the monitor never finds an empty queue
    task automatic chk(input logic [7:0] v, input logic [7:0] e);
        exp_q.push_back(e);
        obs <= v;
        obs_n <= obs_n + 1;
        @(posedge sys_clk);
    endtask : chk
    always @(posedge sys_clk) begin
        if (obs_n != seen_n) begin
            seen_n = obs_n;
            check(obs, exp_q.pop_front());
        end
    end
    function automatic logic [7:0] ch_of(input logic [2:0] c);
        return (c >= 3'h1 && c <= 3'h4) ? 8'h1 << (c - 3'h1) : 8'h0;
    endfunction : ch_of
    task automatic addr(input logic [6:0] a, input logic dir, input logic e);
        u_mst.cond(1'b0);
        u_mst.xfer({a, dir}, 1'b1, rd, ack);
        chk({7'h0, ack}, {7'h0, e});
    endtask : addr
    task automatic report_and_stop();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        report_and_stop();
    end
    // pass 8 uses a foreign address, which must change nothing
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({4'h0, ch_enable}, 8'h0);
        for (int c = 0; c < 9; c++) begin
            addr(CHSEL_DEV_ADDR_DEFAULT, CHSEL_DIR_READ, 1'b0);
            for (int k = 0; k < 3; k++) begin
                u_mst.xfer(8'hff, k == 2, rd, ack);
                chk(rd, {5'h0, cur});
            end
            u_mst.cond(1'b1);
            addr(CHSEL_DEV_ADDR_DEFAULT ^ {6'h0, c[3]}, CHSEL_DIR_WRITE, c[3]);
            n = 1 + ($random(seed) & 3);
            for (int k = 0; k < n; k++) begin
                d = 8'($random(seed));
                if (k == n - 1) d[2:0] = c[2:0] ^ {2'h0, c[3]};
                u_mst.xfer(d, 1'b1, rd, ack);
                chk({7'h0, ack}, {7'h0, c[3]});
            end
            chk({4'h0, ch_enable}, ch_of(cur));
            u_mst.cond(1'b1);
            u_mst.wt(8);
            if (c < 8) cur = c[2:0];
            chk({4'h0, ch_enable}, ch_of(cur));
        end
        repeat (2) @(posedge sys_clk);
        report_and_stop();
    end
endmodule : chsel_target_tb
`default_nettype wire
